// [src/epi_top.v]
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "epi_regs.vh"
module epi_top (
   input wire clk_i,
   input wire reset_i,
   input wire [3:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   input wire ext_irq_pin_zero_i,
   input wire ext_irq_pin_one_i,
   input wire ext_irq_pin_two_i,
   input wire [2:0] vector_done_i,
   output wire [2:0] vector_req_o,
   output wire [1:0] input_enable_override_enable_o,
   output wire [1:0] input_enable_override_value_o
);
   // ----------------------------------------------------------------------
   // Local constants
   // ----------------------------------------------------------------------
   localparam NUM_PINS = 3;
   localparam [2:0] PIN_BITS_RESET = 3'h0;
   localparam [3:0] SENSE_RESET = 4'h0;
   localparam GLOBAL_RESET = 1'b0;

   // ----------------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------------
   // True when the bus address selects the given register offset.
   function addr_is;
      input [3:0] addr;
      input [3:0] offset;
      begin
         addr_is = (addr == offset);
      end
   endfunction

   // Gathers the three per-pin bits from their positions in a bus byte.
   function [2:0] byte_to_pins;
      input [7:0] value;
      begin
         byte_to_pins = {value[`EPI_BIT_PIN_TWO], value[`EPI_BIT_PIN_ONE],
                         value[`EPI_BIT_PIN_ZERO]};
      end
   endfunction

   // Places the three per-pin bits in a bus byte; all other bits read zero.
   function [7:0] pins_to_byte;
      input [2:0] pins;
      begin
         pins_to_byte = 8'h00;
         pins_to_byte[`EPI_BIT_PIN_ZERO] = pins[0];
         pins_to_byte[`EPI_BIT_PIN_ONE] = pins[1];
         pins_to_byte[`EPI_BIT_PIN_TWO] = pins[2];
      end
   endfunction

   // True when a two-bit sense code selects the low-level mode.
   function is_level_mode;
      input [1:0] code;
      begin
         is_level_mode = (code == `EPI_SENSE_LEVEL);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg [2:0] flag_reg;
   reg [2:0] flag_next;
   reg [2:0] enable_reg;
   reg [2:0] enable_next;
   reg [3:0] sense_reg;
   reg [3:0] sense_next;
   reg pin_two_edge_select_reg;
   reg pin_two_edge_select_next;
   reg global_reg;
   reg global_next;
   reg [7:0] rdata_next;
   wire [2:0] pin_level;
   wire [2:0] pin_event;
   wire [2:0] level_req;
   wire [2:0] pin_raw;
   wire [2:0] clr;
   wire [2:0] level_mode;
   wire [2:0] flag_set;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   wire sel_flags = addr_is(addr_i, `EPI_ADDR_FLAGS);
   wire sel_enables = addr_is(addr_i, `EPI_ADDR_ENABLES);
   wire sel_gen_ctrl = addr_is(addr_i, `EPI_ADDR_GEN_CTRL);
   wire sel_ctrl_stat = addr_is(addr_i, `EPI_ADDR_CTRL_STAT);
   wire sel_status_word = addr_is(addr_i, `EPI_ADDR_STATUS_WORD);
   wire wr_flags = wr_i & sel_flags;
   wire wr_enables = wr_i & sel_enables;
   wire wr_gen_ctrl = wr_i & sel_gen_ctrl;
   wire wr_ctrl_stat = wr_i & sel_ctrl_stat;
   wire wr_status_word = wr_i & sel_status_word;
   assign pin_raw = {ext_irq_pin_two_i, ext_irq_pin_one_i, ext_irq_pin_zero_i};

   // ----------------------------------------------------------------------
   // Pin paths
   // ----------------------------------------------------------------------
   // Pins are observed regardless of direction, so driving them as outputs
   // lets software raise its own requests.
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : pin_path
         wire [1:0] sense;
         if (g == 2) begin : two
            assign sense = {1'b1, pin_two_edge_select_reg};
         end else begin : zo
            assign sense = sense_reg[2*g+1:2*g];
         end
         epi_sync sync_u (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .pin_i(pin_raw[g]),
            .level_o(pin_level[g])
         );
         epi_detect det_u (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .level_i(pin_level[g]),
            .sense_i(sense),
            .event_o(pin_event[g]),
            .level_req_o(level_req[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------------
   // An event in the same cycle as a clear keeps the flag set, so that an
   // edge arriving while the routine runs is never lost.
   assign clr = vector_done_i | ({3{wr_flags}} & byte_to_pins(wdata_i));
   // Pin 2 has no level mode, so its flag is never held clear.
   assign level_mode = {1'b0, is_level_mode(sense_reg[3:2]),
                        is_level_mode(sense_reg[1:0])};
   assign flag_set = pin_event & ~level_mode;
   integer i;
   always @* begin
      flag_next = flag_reg;
      for (i = 0; i < NUM_PINS; i = i + 1) begin
         if (level_mode[i]) begin
            flag_next[i] = 1'b0;
         end else begin
            flag_next[i] = (flag_reg[i] & ~clr[i]) | flag_set[i];
         end
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         flag_reg <= PIN_BITS_RESET;
      end else begin
         flag_reg <= flag_next;
      end
   end

   // ----------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------
   // Per-pin request enables.
   always @* begin
      enable_next = enable_reg;
      if (wr_enables) begin
         enable_next = byte_to_pins(wdata_i);
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         enable_reg <= PIN_BITS_RESET;
      end else begin
         enable_reg <= enable_next;
      end
   end

   // Sense codes of pins 0 and 1; a new code takes effect on the next edge.
   always @* begin
      sense_next = sense_reg;
      if (wr_gen_ctrl) begin
         sense_next = wdata_i[3:0];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         sense_reg <= SENSE_RESET;
      end else begin
         sense_reg <= sense_next;
      end
   end

   // Edge select of pin 2.
   always @* begin
      pin_two_edge_select_next = pin_two_edge_select_reg;
      if (wr_ctrl_stat) begin
         pin_two_edge_select_next = wdata_i[`EPI_BIT_TWO_EDGE];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         pin_two_edge_select_reg <= 1'b0;
      end else begin
         pin_two_edge_select_reg <= pin_two_edge_select_next;
      end
   end

   // Local copy of the global interrupt bit; the core owns the real one.
   always @* begin
      global_next = global_reg;
      if (wr_status_word) begin
         global_next = wdata_i[`EPI_BIT_GLOBAL];
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         global_reg <= GLOBAL_RESET;
      end else begin
         global_reg <= global_next;
      end
   end

   // ----------------------------------------------------------------------
   // Requests, one per vector
   // ----------------------------------------------------------------------
   // Each pin owns one request line, so the core vectors to it alone.
   wire [2:0] req_gate = enable_reg & {3{global_reg}};
   wire [2:0] req_source = flag_reg | level_req;
   genvar r;
   generate
      for (r = 0; r < NUM_PINS; r = r + 1) begin : req_line
         assign vector_req_o[r] = req_source[r] & req_gate[r];
      end
   endgenerate

   // The inputs of pins 0 and 1 must stay alive while their requests are enabled, even in sleep.
   genvar v;
   generate
      for (v = 0; v < 2; v = v + 1) begin : ovr_line
         assign input_enable_override_enable_o[v] = enable_reg[v];
         assign input_enable_override_value_o[v] = 1'b1;
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   // Data read zero outside the read slot, so a stale value is never taken.
   always @* begin
      rdata_next = 8'h00;
      if (rd_i) begin
         if (sel_flags) begin
            rdata_next = pins_to_byte(flag_reg);
         end else if (sel_enables) begin
            rdata_next = pins_to_byte(enable_reg);
         end else if (sel_gen_ctrl) begin
            rdata_next = {4'h0, sense_reg};
         end else if (sel_ctrl_stat) begin
            rdata_next = {1'b0, pin_two_edge_select_reg, 6'h00};
         end else if (sel_status_word) begin
            rdata_next = {global_reg, 7'h00};
         end else begin
            rdata_next = 8'h00;
         end
      end else begin
         rdata_next = 8'h00;
      end
   end

   always @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= `EPI_RESET_BYTE;
      end else begin
         rdata_o <= rdata_next;
      end
   end
endmodule
`default_nettype wire

// [src/epi_regs.vh]
`ifndef EPI_REGS_VH
`define EPI_REGS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EPI_ADDR_FLAGS 4'h0
`define EPI_ADDR_ENABLES 4'h1
`define EPI_ADDR_GEN_CTRL 4'h2
`define EPI_ADDR_CTRL_STAT 4'h3
`define EPI_ADDR_STATUS_WORD 4'h4
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EPI_BIT_PIN_ONE 7
`define EPI_BIT_PIN_ZERO 6
`define EPI_BIT_PIN_TWO 5
`define EPI_BIT_GLOBAL 7
`define EPI_BIT_ONE_SENSE_LO 2
`define EPI_BIT_ZERO_SENSE_LO 0
`define EPI_BIT_TWO_EDGE 6
// ----------------------------------------------------------------------
// Sense codes and reset values
// ----------------------------------------------------------------------
`define EPI_SENSE_LEVEL 2'h0
`define EPI_SENSE_ANY 2'h1
`define EPI_SENSE_FALL 2'h2
`define EPI_SENSE_RISE 2'h3
`define EPI_RESET_BYTE 8'h00
`endif

// [src/epi_sync.v]
`timescale 1ns/1ps
`default_nettype none
module epi_sync (
   input wire clk_i,
   input wire reset_i,
   input wire pin_i,
   output wire level_o
);
   reg meta_reg;
   reg level_reg;
   always @(posedge clk_i) begin
      if (reset_i) begin
         meta_reg <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         level_reg <= meta_reg;
      end
   end
   assign level_o = level_reg;
endmodule
`default_nettype wire

// [src/epi_detect.v]
`timescale 1ns/1ps
`default_nettype none
`include "epi_regs.vh"
module epi_detect (
   input wire clk_i,
   input wire reset_i,
   input wire level_i,
   input wire [1:0] sense_i,
   output wire event_o,
   output wire level_req_o
);
   reg last_reg;
   always @(posedge clk_i) begin
      if (reset_i) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= level_i;
      end
   end
   wire rise = level_i & ~last_reg;
   wire fall = ~level_i & last_reg;
   assign event_o = (sense_i == `EPI_SENSE_ANY) ? (rise | fall) :
                    (sense_i == `EPI_SENSE_FALL) ? fall :
                    (sense_i == `EPI_SENSE_RISE) ? rise : 1'b0;
   // A low level requests continuously and sets no flag.
   assign level_req_o = (sense_i == `EPI_SENSE_LEVEL) & ~level_i;
endmodule
`default_nettype wire

// [dv/epi_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Far-side sources; any level at any time is legal, as on a pin set as output.
module epi_pin_model (
   input wire logic clk_i,
   input wire logic [2:0] level_i,
   output var logic [2:0] pin_o
);
   always_ff @(posedge clk_i) pin_o <= #1 level_i;
endmodule
`default_nettype wire

// [dv/epi_top_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module epi_top_checker (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [3:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic ext_irq_pin_zero_i,
   input wire logic [2:0] vector_req_o,
   input wire logic [1:0] input_enable_override_enable_o,
   input wire logic [1:0] input_enable_override_value_o
);
   // Shadows of the enable, sense and global registers, because only the bus reveals them.
   logic [7:0] en_reg, sn_reg, gl_reg;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         en_reg <= 8'h00;
         sn_reg <= 8'h00;
         gl_reg <= 8'h00;
      end else if (wr_i) begin
         if (addr_i == 4'h1) en_reg <= wdata_i;
         if (addr_i == 4'h2) sn_reg <= wdata_i;
         if (addr_i == 4'h4) gl_reg <= wdata_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_gate0; vector_req_o[0] |-> en_reg[6] && gl_reg[7]; endproperty
   a_gate0: assert property (p_gate0) else $error("pin zero request not gated");
   property p_gate2; vector_req_o[2] |-> en_reg[5] && gl_reg[7]; endproperty
   a_gate2: assert property (p_gate2) else $error("pin two request not gated");
   property p_gate1; vector_req_o[1] |-> en_reg[7] && gl_reg[7]; endproperty
   a_gate1: assert property (p_gate1) else $error("pin one request not gated");
   property p_ovr_en; input_enable_override_enable_o == en_reg[7:6]; endproperty
   a_ovr_en: assert property (p_ovr_en) else $error("override enable wrong");
   property p_ovr_val; input_enable_override_value_o == 2'h3; endproperty
   a_ovr_val: assert property (p_ovr_val) else $error("override value wrong");
   property p_rsvd; rd_i && addr_i == 4'h0 |=> rdata_o[4:0] == 5'h00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved flag bits set");
   property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data outside read slot");
   property p_level;
      (!ext_irq_pin_zero_i) [*3] ##0 (sn_reg[1:0] == 2'h0 && en_reg[6] && gl_reg[7])
         |-> vector_req_o[0];
   endproperty
   a_level: assert property (p_level) else $error("low level gave no request");
   property p_lvlflag;
      rd_i && addr_i == 4'h0 && sn_reg[1:0] == 2'h0 && $past(sn_reg[1:0]) == 2'h0
         |=> rdata_o[6] == 1'b0;
   endproperty
   a_lvlflag: assert property (p_lvlflag) else $error("level mode flag not clear");
   c_req0: cover property (vector_req_o[0]);
   c_req1: cover property (vector_req_o[1]);
   c_req2: cover property (vector_req_o[2]);
   c_read: cover property (rd_i && addr_i == 4'h0);
endmodule
bind epi_top epi_top_checker u_chk (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
   .rdata_o, .ext_irq_pin_zero_i, .vector_req_o, .input_enable_override_enable_o,
   .input_enable_override_value_o);
`default_nettype wire

// [dv/epi_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module epi_top_bench;
   logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic [2:0] lvl = 3'h2, pins, vector_done_i = 3'h0, vector_req_o;
   int n_errors = 0, num_checks = 0;
   always #2.5 clk_i = ~clk_i;
   epi_pin_model u_pins (.clk_i, .level_i(lvl), .pin_o(pins));
   epi_top DUT (.clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .ext_irq_pin_zero_i(pins[0]), .ext_irq_pin_one_i(pins[1]),
      .ext_irq_pin_two_i(pins[2]), .vector_done_i, .vector_req_o,
      .input_enable_override_enable_o(), .input_enable_override_value_o());
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", exp, rdata_o);
   endtask
   task automatic pins_to(input logic [2:0] v);
      @(posedge clk_i) lvl <= v;
      repeat (5) @(posedge clk_i);
   endtask
   task final_report;
      if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(4'h0, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      wr(4'h1, 8'hE0);
      wr(4'h4, 8'h80);
      wr(4'h2, 8'h0B);
      wr(4'h3, 8'h40);
      pins_to(3'h5);
      rd(4'h0, 8'hE0);
      chk("vector_req", 8'h07, {5'h00, vector_req_o});
      wr(4'h0, 8'h40);
      wr(4'h0, 8'h00);
      rd(4'h0, 8'hA0);
      @(posedge clk_i) vector_done_i <= 3'h4;
      @(posedge clk_i) vector_done_i <= 3'h0;
      rd(4'h0, 8'h80);
      wr(4'h4, 8'h00);
      #1 chk("vector_req", 8'h00, {5'h00, vector_req_o});
      wr(4'h4, 8'h80);
      wr(4'h2, 8'h08);
      pins_to(3'h4);
      rd(4'h0, 8'h80);
      chk("vector_req", 8'h03, {5'h00, vector_req_o});
      wr(4'h2, 8'h09);
      wr(4'h3, 8'h00);
      pins_to(3'h1);
      rd(4'h0, 8'hE0);
      @(posedge clk_i) vector_done_i <= 3'h3;
      @(posedge clk_i) vector_done_i <= 3'h0;
      rd(4'h0, 8'h20);
      wr(4'h2, 8'h0D);
      pins_to(3'h2);
      rd(4'h0, 8'hE0);
      wr(4'h2, 8'h01);
      rd(4'h0, 8'h60);
      chk("vector_req", 8'h05, {5'h00, vector_req_o});
      @(posedge clk_i) reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1 chk("vector_req", 8'h00, {5'h00, vector_req_o});
      rd(4'h0, 8'h00);
      final_report;
   end
endmodule
`default_nettype wire
